/* design/ahd_handler.sv */
// acknowledgement handler object: service interpreter and retry timing
`timescale 1ns/1ps
// Functional notes
// - successful set of retry limit clears the retry counter
// - ack list grows or shrinks as associated connections change state
// - producing connection instance is read-only while ack list is non-empty
// - creation loads acknowledgement timer with 16 ms
// - creation loads retry limit with 1
// - undefined attribute identifiers are reserved and rejected
// - get service returns the addressed attribute value
// - set service writes the addressed instance attribute
// - create service at class level makes a new instance
// - delete service supported at class and instance level
// - class delete removes all instances, instance delete removes one
// - timer restarts on every data-sent or data-resent indication if its value is non-zero; with a value of 0 it stops
// - timer expiry sends a time-out indication to the application
// - each time-out bumps retry count unless a retry-limit write clears it in that cycle; reaching limit signals retry-limit-reached
// - data-sent clears retry count, data-resent leaves it alone
module ahd_handler (
	input  wire logic                  i_clock,      // system clock, 125 MHz
	input  wire logic                  i_rstn,       // synchronous reset, active low
	input  wire logic                  i_req_valid,  // one-cycle request strobe
	input  wire ahd_pkg::ahd_req_type  i_req,        // request fields
	input  wire logic                  i_conn_event, // one-cycle connection state change
	input  wire logic [1:0]            i_conn_inst,  // handler instance of that connection
	input  wire ahd_pkg::ahd_conn_type i_conn_old,   // state left
	input  wire ahd_pkg::ahd_conn_type i_conn_new,   // state entered
	input  wire logic [1:0]            i_prod_inst,  // handler instance that produced
	input  wire logic                  i_data_sent,  // new data produced, pulse
	input  wire logic                  i_data_resent,// data re-produced, pulse
	output logic                       o_rsp_valid,  // one-cycle response strobe
	output ahd_pkg::ahd_rsp_type       o_rsp,        // response fields
	output logic [3:0]                 o_timeout,    // time-out indication per instance, pulse
	output logic [3:0]                 o_retry_limit,// retry limit reached per instance, pulse
	output logic [3:0]                 o_exists      // instance exists
);
	import ahd_pkg::*;

	// ------------------------------------------------------------
	// instance state
	// ------------------------------------------------------------
	logic [NUM_INST-1:0] exist_q;
	logic [15:0]         timer_q   [NUM_INST];
	logic [7:0]          rlim_q    [NUM_INST];
	logic [7:0]          rcnt_q    [NUM_INST];
	logic [15:0]         prod_q    [NUM_INST];
	logic [3:0]          acks_q    [NUM_INST];
	logic [15:0]         ms_left_q [NUM_INST];
	logic [NUM_INST-1:0] run_q;
	logic [16:0]         div_q;
	logic                ms_tick_q;
	ahd_rsp_type         rsp_q;
	logic                rsp_v_q;
	logic [3:0]          tmo_q;
	logic [3:0]          lim_q;

	// ------------------------------------------------------------
	// request decode
	// ------------------------------------------------------------
	wire       svc_get   = i_req.service == SVC_GET;
	wire       svc_set   = i_req.service == SVC_SET;
	wire       svc_crt   = i_req.service == SVC_CREATE;
	wire       svc_del   = i_req.service == SVC_DELETE;
	wire [1:0] ri        = i_req.inst;
	wire       inst_ok   = exist_q[ri];
	wire       attr_def  = i_req.attribute inside {ATTR_ACK_COUNT, ATTR_TIMER, ATTR_RETRY_LIM, ATTR_PROD_INST};
	wire       attr_wr   = i_req.attribute inside {ATTR_TIMER, ATTR_RETRY_LIM, ATTR_PROD_INST};
	wire       prod_lock = acks_q[ri] != 4'h0;
	wire       has_free  = ~&exist_q;
	logic [1:0] free_idx;
	always_comb begin
		free_idx = 2'd0;
		for (int k = NUM_INST - 1; k >= 0; k--) begin
			if (!exist_q[k]) begin
				free_idx = 2'(k);
			end
		end
	end

	// one status per request; anything not OK leaves every attribute alone
	logic [7:0]  st_d;
	logic [15:0] val_d;
	always_comb begin
		st_d  = ST_OK;
		val_d = 16'h0000;
		if (i_req.to_class) begin
			if (svc_crt) begin
				st_d  = has_free ? ST_OK : ST_NO_ROOM;
				val_d = {14'h0000, free_idx};
			end else if (svc_del) begin
				st_d = ST_OK;
			end else if (svc_get) begin
				st_d  = (i_req.attribute == ATTR_ACK_COUNT) ? ST_OK : ST_NO_ATTR;
				val_d = {12'h000, 1'b0, 3'(exist_q[0]) + 3'(exist_q[1]) + 3'(exist_q[2]) + 3'(exist_q[3])};
			end else begin
				st_d = ST_NO_SVC;
			end
		end else if (!(svc_get || svc_set || svc_del)) begin
			st_d = ST_NO_SVC;
		end else if (!inst_ok) begin
			st_d = ST_NO_INST;
		end else if (svc_get) begin
			st_d = attr_def ? ST_OK : ST_NO_ATTR;
			unique case (i_req.attribute)
				ATTR_ACK_COUNT: val_d = {12'h000, acks_q[ri]};
				ATTR_TIMER:     val_d = timer_q[ri];
				ATTR_RETRY_LIM: val_d = {8'h00, rlim_q[ri]};
				ATTR_PROD_INST: val_d = prod_q[ri];
				default:        val_d = 16'h0000;
			endcase
		end else if (svc_set) begin
			if (!attr_wr) begin
				st_d = attr_def ? ST_READ_ONLY : ST_NO_ATTR;
			end else if (i_req.attribute == ATTR_PROD_INST && prod_lock) begin
				st_d = ST_READ_ONLY;
			end
		end
	end

	wire req_ok = i_req_valid && st_d == ST_OK;

	// ------------------------------------------------------------
	// millisecond enable
	// ------------------------------------------------------------
	// one shared divider: a restart aligns only to the next tick, so a period can run up to 1 ms short
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			div_q     <= 17'h00000;
			ms_tick_q <= 1'b0;
		end else begin
			ms_tick_q <= div_q == MS_TICK_LAST;
			div_q     <= (div_q == MS_TICK_LAST) ? 17'h00000 : div_q + 17'h00001;
		end
	end

	// ------------------------------------------------------------
	// per-instance attributes and retry logic
	// ------------------------------------------------------------
	for (genvar g = 0; g < NUM_INST; g++) begin : g_inst
		wire hit      = req_ok && ri == 2'(g) && !i_req.to_class;
		wire create   = req_ok && i_req.to_class && svc_crt && free_idx == 2'(g);
		wire remove   = req_ok && svc_del && (i_req.to_class || ri == 2'(g));
		wire wr_timer = hit && svc_set && i_req.attribute == ATTR_TIMER;
		wire wr_rlim  = hit && svc_set && i_req.attribute == ATTR_RETRY_LIM;
		wire wr_prod  = hit && svc_set && i_req.attribute == ATTR_PROD_INST;
		wire produce  = (i_data_sent || i_data_resent) && i_prod_inst == 2'(g) && exist_q[g];
		wire expire   = run_q[g] && ms_tick_q && ms_left_q[g] <= 16'h0001;
		wire cev      = i_conn_event && i_conn_inst == 2'(g) && exist_q[g];
		wire add_ack  = cev && i_conn_new == CONN_ESTAB && i_conn_old != CONN_ESTAB && acks_q[g] != 4'(ACK_MAX);
		wire del_ack  = cev && i_conn_old == CONN_ESTAB && i_conn_new != CONN_ESTAB && acks_q[g] != 4'h0;
		wire [7:0] rcnt_inc = rcnt_q[g] + 8'h01;

		always_ff @(posedge i_clock) begin
			if (!i_rstn || remove) begin
				exist_q[g]   <= 1'b0;
				timer_q[g]   <= TIMER_DEF_MS;
				rlim_q[g]    <= RETRY_DEF;
				rcnt_q[g]    <= 8'h00;
				prod_q[g]    <= PROD_DEF;
				acks_q[g]    <= 4'h0;
				run_q[g]     <= 1'b0;
				ms_left_q[g] <= 16'h0000;
				tmo_q[g]     <= 1'b0;
				lim_q[g]     <= 1'b0;
			end else begin
				tmo_q[g] <= 1'b0;
				lim_q[g] <= 1'b0;
				if (create) begin
					exist_q[g] <= 1'b1;
					timer_q[g] <= TIMER_DEF_MS;
					rlim_q[g]  <= RETRY_DEF;
					rcnt_q[g]  <= 8'h00;
				end
				if (wr_timer) begin
					timer_q[g] <= i_req.value;
				end
				if (wr_prod) begin
					prod_q[g] <= i_req.value;
				end
				if (add_ack) begin
					acks_q[g] <= acks_q[g] + 4'h1;
				end else if (del_ack) begin
					acks_q[g] <= acks_q[g] - 4'h1;
				end
				if (produce) begin
					run_q[g]     <= timer_q[g] != 16'h0000;
					ms_left_q[g] <= timer_q[g];
				end else if (expire) begin
					run_q[g] <= 1'b0;
					tmo_q[g] <= 1'b1;
				end else if (run_q[g] && ms_tick_q) begin
					ms_left_q[g] <= ms_left_q[g] - 16'h0001;
				end
				// priority: retry-limit write, then data-sent clear, then time-out count
				if (wr_rlim) begin
					rlim_q[g] <= i_req.value[7:0];
					rcnt_q[g] <= 8'h00;
				end else if (i_data_sent && produce) begin
					rcnt_q[g] <= 8'h00;
				end else if (expire && !produce) begin
					rcnt_q[g] <= rcnt_inc;
					lim_q[g]  <= rcnt_inc >= rlim_q[g];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// response
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			rsp_v_q <= 1'b0;
			rsp_q   <= '0;
		end else begin
			rsp_v_q <= i_req_valid;
			if (i_req_valid) begin
				rsp_q <= '{status: st_d, inst: ri, value: val_d};
			end
		end
	end

	assign o_rsp_valid   = rsp_v_q;
	assign o_rsp         = rsp_q;
	assign o_timeout     = tmo_q;
	assign o_retry_limit = lim_q;
	assign o_exists      = exist_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_SET_LIM_CLEARS: assert property (@(posedge i_clock) disable iff (!i_rstn)
		req_ok && !i_req.to_class && svc_set && i_req.attribute == ATTR_RETRY_LIM && !svc_del
		|=> rcnt_q[$past(ri)] == 8'h00)
		else $error("retry count not cleared by limit write");
	AST_PROD_LOCK: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_req_valid && !i_req.to_class && svc_set && inst_ok && i_req.attribute == ATTR_PROD_INST
		&& acks_q[ri] != 4'h0 |=> o_rsp.status == ST_READ_ONLY && prod_q[$past(ri)] == $past(prod_q[ri]))
		else $error("producing instance written while locked");
	AST_CREATE_DEF: assert property (@(posedge i_clock) disable iff (!i_rstn)
		req_ok && i_req.to_class && svc_crt |=> timer_q[$past(free_idx)] == TIMER_DEF_MS
		&& rlim_q[$past(free_idx)] == RETRY_DEF)
		else $error("created instance lacks defaults");
	AST_RESERVED: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_req_valid && !i_req.to_class && inst_ok && svc_get && !attr_def |=> o_rsp_valid
		&& o_rsp.status == ST_NO_ATTR)
		else $error("reserved attribute accepted");
	AST_GET_TIMER: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_req_valid && !i_req.to_class && inst_ok && svc_get && i_req.attribute == ATTR_TIMER
		|=> o_rsp.value == $past(timer_q[ri]))
		else $error("get returned wrong timer value");
	AST_CLASS_DELETE: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_req_valid && i_req.to_class && svc_del |=> o_exists == 4'h0)
		else $error("class delete left instances");
	AST_TIMEOUT_AFTER: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_timeout[0] |-> $past(run_q[0], 1) && !run_q[0])
		else $error("time-out without running timer");
	AST_SENT_CLEARS: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_data_sent && i_prod_inst == 2'd0 && exist_q[0] && !(i_req_valid && svc_del)
		&& !(req_ok && svc_set) |=> rcnt_q[0] == 8'h00)
		else $error("data-sent did not clear retry count");
	AST_BAD_SVC: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_req_valid && i_req.to_class && svc_set |=> o_rsp.status == ST_NO_SVC && $stable(o_exists))
		else $error("set at class level not rejected");
endmodule

/* design/ahd_pkg.sv */
// package: constants and carriers for the acknowledgement handler object
package ahd_pkg;
	// ------------------------------------------------------------
	// service codes
	// ------------------------------------------------------------
	localparam logic [7:0] SVC_GET    = 8'h0e;
	localparam logic [7:0] SVC_SET    = 8'h10;
	localparam logic [7:0] SVC_CREATE = 8'h08;
	localparam logic [7:0] SVC_DELETE = 8'h09;

	// ------------------------------------------------------------
	// attribute identifiers and defaults
	// ------------------------------------------------------------
	localparam logic [7:0]  ATTR_TIMER     = 8'h02;
	localparam logic [7:0]  ATTR_RETRY_LIM = 8'h03;
	localparam logic [7:0]  ATTR_PROD_INST = 8'h04;
	localparam logic [7:0]  ATTR_ACK_COUNT = 8'h01;
	localparam logic [15:0] TIMER_DEF_MS   = 16'h0010;
	localparam logic [7:0]  RETRY_DEF      = 8'h01;
	localparam logic [15:0] PROD_DEF       = 16'h0000;

	// ------------------------------------------------------------
	// sizes and timing
	// ------------------------------------------------------------
	localparam int          NUM_INST     = 4;
	localparam int          ACK_MAX      = 8;
	localparam int          CLK_MHZ      = 125;
	localparam int          MS_CYCLES    = CLK_MHZ * 1000;
	localparam logic [16:0] MS_TICK_LAST = 17'(MS_CYCLES - 1);

	// ------------------------------------------------------------
	// response status
	// ------------------------------------------------------------
	localparam logic [7:0] ST_OK        = 8'h00;
	localparam logic [7:0] ST_NO_SVC    = 8'h08;
	localparam logic [7:0] ST_NO_ATTR   = 8'h14;
	localparam logic [7:0] ST_READ_ONLY = 8'h0e;
	localparam logic [7:0] ST_NO_INST   = 8'h16;
	localparam logic [7:0] ST_NO_ROOM   = 8'h02;

	typedef struct packed {
		logic [7:0]  service;
		logic        to_class;
		logic [1:0]  inst;
		logic [7:0]  attribute;
		logic [15:0] value;
	} ahd_req_type;

	typedef struct packed {
		logic [7:0]  status;
		logic [1:0]  inst;
		logic [15:0] value;
	} ahd_rsp_type;

	typedef enum logic [1:0] {
		CONN_NONE   = 2'b00,
		CONN_CONFIG = 2'b01,
		CONN_ESTAB  = 2'b11,
		CONN_TIMED  = 2'b10
	} ahd_conn_type;
endpackage

/* tb/ahd_client_model.sv */
// client model: remote requester, connection events and the producing application
`timescale 1ns/1ps
module ahd_client_model (
	input  wire logic          i_clock,       // system clock
	input  wire logic          i_rsp_valid,   // response strobe from the handler
	input  wire ahd_pkg::ahd_rsp_type i_rsp,  // response fields
	output logic               o_req_valid,   // request strobe
	output ahd_pkg::ahd_req_type o_req,       // request fields
	output logic               o_conn_event,  // connection change pulse
	output logic [1:0]         o_conn_inst,   // handler owning the connection
	output ahd_pkg::ahd_conn_type o_conn_old, // state left
	output ahd_pkg::ahd_conn_type o_conn_new, // state entered
	output logic [1:0]         o_prod_inst,   // producing handler
	output logic               o_data_sent,   // new production pulse
	output logic               o_data_resent  // retry production pulse
);
	import ahd_pkg::*;

	initial begin
		o_req_valid = 1'h0;
		o_req = '0;
		o_conn_event = 1'h0;
		o_conn_inst = 2'h0;
		o_conn_old = CONN_NONE;
		o_conn_new = CONN_NONE;
		o_prod_inst = 2'h0;
		o_data_sent = 1'h0;
		o_data_resent = 1'h0;
	end

	// ------------------------------------------------------------
	// access tasks, entered just after a rising edge
	// ------------------------------------------------------------
	task automatic request(input ahd_req_type rq, output ahd_rsp_type rs, output logic got);
		int n;
		n = 0;
		o_req = rq;
		o_req_valid = 1'h1;
		@(posedge i_clock);
		#1;
		o_req_valid = 1'h0;
		// released fields must not look like the request just taken
		o_req = ~rq;
		while (i_rsp_valid !== 1'h1 && n < 4) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		got = i_rsp_valid;
		rs = i_rsp;
		@(posedge i_clock);
		#1;
	endtask

	task automatic produce(input logic [1:0] inst, input logic resend);
		o_prod_inst = inst;
		o_data_sent = ~resend;
		o_data_resent = resend;
		@(posedge i_clock);
		#1;
		o_data_sent = 1'h0;
		o_data_resent = 1'h0;
		o_prod_inst = ~inst;
		// one idle cycle so a following call never re-raises the strobe in the same step
		@(posedge i_clock);
		#1;
	endtask

	task automatic conn(input logic [1:0] inst, input ahd_conn_type from, input ahd_conn_type to);
		o_conn_inst = inst;
		o_conn_old = from;
		o_conn_new = to;
		o_conn_event = 1'h1;
		@(posedge i_clock);
		#1;
		o_conn_event = 1'h0;
		o_conn_inst = ~inst;
		o_conn_old = ahd_conn_type'(~from);
		o_conn_new = ahd_conn_type'(~to);
	endtask
endmodule

/* tb/ahd_handler_tb.sv */
// testbench: services, ack list, timers and retry indications of the handler
`timescale 1ns/1ps
module ahd_handler_tb;
	import ahd_pkg::*;
	localparam int CYCLE_LIMIT = 140000;
	logic         clock = 1'h0;
	logic         rstn = 1'h0;
	logic         req_valid;
	ahd_req_type  req;
	logic         conn_event;
	logic [1:0]   conn_inst;
	ahd_conn_type conn_old;
	ahd_conn_type conn_new;
	logic [1:0]   prod_inst;
	logic         data_sent;
	logic         data_resent;
	logic         rsp_valid;
	ahd_rsp_type  rsp;
	logic [3:0]   timeout;
	logic [3:0]   retry_limit;
	logic [3:0]   exists;
	int           error_cnt = 0;
	int           checks = 0;
	int           cycles = 0;
	int           n;

	always #4 clock = ~clock;

	ahd_handler i_dut (.i_clock(clock), .i_rstn(rstn), .i_req_valid(req_valid), .i_req(req),
		.i_conn_event(conn_event), .i_conn_inst(conn_inst), .i_conn_old(conn_old), .i_conn_new(conn_new),
		.i_prod_inst(prod_inst), .i_data_sent(data_sent), .i_data_resent(data_resent),
		.o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_timeout(timeout), .o_retry_limit(retry_limit),
		.o_exists(exists));

	ahd_client_model i_client (.i_clock(clock), .i_rsp_valid(rsp_valid), .i_rsp(rsp),
		.o_req_valid(req_valid), .o_req(req), .o_conn_event(conn_event), .o_conn_inst(conn_inst),
		.o_conn_old(conn_old), .o_conn_new(conn_new), .o_prod_inst(prod_inst),
		.o_data_sent(data_sent), .o_data_resent(data_resent));

	// ------------------------------------------------------------
	// compare, request and report tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// value is compared only where a successful get or create returns one
	task automatic tx(input logic [7:0] svc, input logic cls, input logic [1:0] inst, input logic [7:0] attr,
		input logic [15:0] val, input logic [7:0] st, input logic [15:0] exp);
		ahd_rsp_type rs;
		logic        got;
		i_client.request('{svc, cls, inst, attr, val}, rs, got);
		chk("response strobe", 16'h0001, 16'(got));
		chk("status", 16'(st), 16'(rs.status));
		chk("instance", 16'(inst), 16'(rs.inst));
		if (st == ST_OK && (svc == SVC_GET || svc == SVC_CREATE)) chk("value", exp, rs.value);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == CYCLE_LIMIT) begin
			error_cnt++;
			$display("[ERR] run length expected %0d seen %0d", CYCLE_LIMIT - 1, cycles);
			summarize();
		end
	end

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clock);
		#1;
		chk("exists", 16'h0000, 16'(exists));
		rstn = 1'h1;
		tx(SVC_CREATE, 1'h1, 2'h0, 8'h00, 16'h0000, ST_OK, 16'h0000);
		tx(SVC_CREATE, 1'h1, 2'h0, 8'h00, 16'h0000, ST_OK, 16'h0001);
		tx(SVC_CREATE, 1'h1, 2'h0, 8'h00, 16'h0000, ST_OK, 16'h0002);
		tx(SVC_CREATE, 1'h0, 2'h0, 8'h00, 16'h0000, ST_NO_SVC, 16'h0000);
		chk("exists", 16'h0007, 16'(exists));
		tx(SVC_GET, 1'h0, 2'h1, ATTR_TIMER, 16'h0000, ST_OK, 16'h0010);
		tx(SVC_GET, 1'h0, 2'h1, ATTR_RETRY_LIM, 16'h0000, ST_OK, 16'h0001);
		tx(SVC_GET, 1'h1, 2'h0, ATTR_ACK_COUNT, 16'h0000, ST_OK, 16'h0003);
		$display("test create done");
		tx(SVC_SET, 1'h0, 2'h0, ATTR_TIMER, 16'h0001, ST_OK, 16'h0000);
		tx(SVC_SET, 1'h1, 2'h0, ATTR_TIMER, 16'h0005, ST_NO_SVC, 16'h0000);
		tx(SVC_GET, 1'h0, 2'h0, ATTR_TIMER, 16'h0000, ST_OK, 16'h0001);
		tx(SVC_SET, 1'h0, 2'h1, ATTR_TIMER, 16'h0001, ST_OK, 16'h0000);
		tx(SVC_SET, 1'h0, 2'h1, ATTR_RETRY_LIM, 16'h0002, ST_OK, 16'h0000);
		tx(SVC_GET, 1'h0, 2'h1, ATTR_RETRY_LIM, 16'h0000, ST_OK, 16'h0002);
		tx(SVC_SET, 1'h0, 2'h2, ATTR_TIMER, 16'h0000, ST_OK, 16'h0000);
		tx(SVC_GET, 1'h0, 2'h0, 8'h05, 16'h0000, ST_NO_ATTR, 16'h0000);
		tx(SVC_SET, 1'h0, 2'h0, 8'h00, 16'h0001, ST_NO_ATTR, 16'h0000);
		tx(8'h4b, 1'h0, 2'h0, ATTR_TIMER, 16'h0000, ST_NO_SVC, 16'h0000);
		tx(SVC_GET, 1'h0, 2'h3, ATTR_TIMER, 16'h0000, ST_NO_INST, 16'h0000);
		$display("test attributes done");
		i_client.conn(2'h2, CONN_CONFIG, CONN_ESTAB);
		tx(SVC_GET, 1'h0, 2'h2, ATTR_ACK_COUNT, 16'h0000, ST_OK, 16'h0001);
		tx(SVC_SET, 1'h0, 2'h2, ATTR_PROD_INST, 16'h0003, ST_READ_ONLY, 16'h0000);
		tx(SVC_GET, 1'h0, 2'h2, ATTR_PROD_INST, 16'h0000, ST_OK, 16'h0000);
		i_client.conn(2'h2, CONN_ESTAB, CONN_TIMED);
		tx(SVC_GET, 1'h0, 2'h2, ATTR_ACK_COUNT, 16'h0000, ST_OK, 16'h0000);
		tx(SVC_SET, 1'h0, 2'h2, ATTR_PROD_INST, 16'h0003, ST_OK, 16'h0000);
		tx(SVC_GET, 1'h0, 2'h2, ATTR_PROD_INST, 16'h0000, ST_OK, 16'h0003);
		$display("test ack list done");
		tx(SVC_CREATE, 1'h1, 2'h0, 8'h00, 16'h0000, ST_OK, 16'h0003);
		tx(SVC_CREATE, 1'h1, 2'h0, 8'h00, 16'h0000, ST_NO_ROOM, 16'h0000);
		tx(SVC_DELETE, 1'h0, 2'h3, 8'h00, 16'h0000, ST_OK, 16'h0000);
		chk("exists", 16'h0007, 16'(exists));
		$display("test instance count done");
		i_client.produce(2'h0, 1'h0);
		i_client.produce(2'h1, 1'h0);
		i_client.produce(2'h2, 1'h1);
		n = 0;
		// one ms tick is far off; the wait is bounded a little past it
		while (timeout === 4'h0 && n < 130000) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk("timeout", 16'h0003, 16'(timeout));
		chk("retry limit", 16'h0001, 16'(retry_limit));
		@(posedge clock);
		#1;
		chk("timeout", 16'h0000, 16'(timeout));
		$display("test timer done");
		tx(SVC_DELETE, 1'h1, 2'h0, 8'h00, 16'h0000, ST_OK, 16'h0000);
		chk("exists", 16'h0000, 16'(exists));
		tx(SVC_GET, 1'h0, 2'h0, ATTR_TIMER, 16'h0000, ST_NO_INST, 16'h0000);
		$display("test delete done");
		summarize();
	end
endmodule
